// file: rtl/sba_ctrl.v
/*
  Software serial bus access control: data, index, target address and
  control/status bytes in configuration space, EEPROM presence strap
  sampling and the automatic register-default download.
  Assumes a byte-wide configuration port in the ref_clk domain, resetn as
  the fundamental reset, and open-drain bus pins resolved outside.
*/
`include "sba_map.vh"

// Functional notes
// - a write to the target address register starts a bus cycle
// - target address register resets to 0xa0
// - target address bits 7:1 give the seven-bit bus address
// - target address bit 0: zero writes one byte, one reads one byte
// - control bit 7 clear sends address and index; set sends address only
// - control bits 6 and 2 read as zero
// - status bit 5 is high while a software cycle runs
// - status bit 4 is high while the EEPROM download runs
// - status bit 3 is set when the strap shows an EEPROM
// - bit 3 enables software bus cycles; the EEPROM download runs whatever its value
// - presence is sampled once after fundamental or global reset
// - software may set bit 3 itself to enable the interface
// - all fields but the target address clear on fundamental reset; control reads 0x00
// - a read cycle leaves its byte in the data register by busy clear
// - status bit 1 flags a failed software cycle; reading clears it
module sba_ctrl #(
  parameter QTR_CYC = `SBA_QTR_CYC,
  parameter DL_BYTES = 8
)(
  input wire ref_clk,
  input wire resetn,
  input wire cfg_wr,
  input wire cfg_rd,
  input wire [7:0] cfg_addr,
  input wire [7:0] cfg_wdata,
  output reg [7:0] cfg_rdata,
  output reg cfg_rvalid,
  input wire eeprom_strap,
  input wire global_reset,
  input wire sda_in,
  output reg sda_out,
  output wire sda_oe,
  output reg scl_out,
  output wire scl_oe,
  output reg dl_valid,
  output reg [7:0] dl_index,
  output reg [7:0] dl_data
);

  localparam integer DL_LAST_I = DL_BYTES - 1;
  localparam [7:0] DL_LAST = DL_LAST_I[7:0];

  // ----------------------------------------------------------------------
  // registers and wires
  // ----------------------------------------------------------------------
  reg [7:0] data_reg;
  reg [7:0] index_reg;
  reg [7:0] target_reg;
  reg mode_reg;
  reg enable_reg;
  reg sw_busy_reg;
  reg dl_active_reg;
  reg sw_err_reg;
  reg rom_err_reg;
  reg dl_wait_reg;
  reg [7:0] dl_idx_reg;
  reg eng_start_reg;
  reg pend_reg;
  reg [1:0] settle_reg;
  reg sda_s1;
  reg sda_s2;
  reg strap_s1;
  reg strap_s2;
  reg global_reset_s1;
  reg global_reset_s2;
  wire eng_busy;
  wire eng_done;
  wire eng_err;
  wire [7:0] eng_rd_data;
  wire sw_go;
  wire dl_go;
  wire ctrl_read;
  wire [7:0] status_byte;

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  // the strap, global reset and data line all come from outside ref_clk
  always @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      strap_s1 <= 1'b0;
      strap_s2 <= 1'b0;
      global_reset_s1 <= 1'b0;
      global_reset_s2 <= 1'b0;
    end
    else
    begin
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      strap_s1 <= eeprom_strap;
      strap_s2 <= strap_s1;
      global_reset_s1 <= global_reset;
      global_reset_s2 <= global_reset_s1;
    end
  end

  // ----------------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------------
  function hit;
    input [7:0] a;
    input [7:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  // write to target starts cycle
  // refused while either busy bit is up; the byte is still stored during the download, not during a software cycle
  assign sw_go = cfg_wr & hit(cfg_addr, `SBA_OFF_TARGET) & enable_reg &
                 ~sw_busy_reg & ~dl_active_reg & ~eng_busy & ~eng_start_reg;
  assign dl_go = dl_active_reg & ~dl_wait_reg & ~eng_busy & ~eng_start_reg;
  assign ctrl_read = cfg_rd & hit(cfg_addr, `SBA_OFF_CTRL);

  assign status_byte = {mode_reg, 1'b0, sw_busy_reg, dl_active_reg,
                        enable_reg, 1'b0, sw_err_reg, rom_err_reg};

  // ----------------------------------------------------------------------
  // presence strap sampling
  // ----------------------------------------------------------------------
  // waits out the synchroniser after reset so a stale strap is not caught
  always @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      pend_reg <= 1'b1;
      settle_reg <= 2'h0;
    end
    else if (global_reset_s2)
    begin
      pend_reg <= 1'b1;
      settle_reg <= 2'h0;
    end
    else if (pend_reg && !eng_busy && !dl_active_reg)
    begin
      if (settle_reg == `SBA_SETTLE_CYC)
        pend_reg <= 1'b0;
      else
        settle_reg <= settle_reg + 2'h1;
    end
  end

  // ----------------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------------
  always @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      data_reg <= `SBA_RST_DATA;
      index_reg <= `SBA_RST_INDEX;
      target_reg <= `SBA_RST_TARGET;
      mode_reg <= |(`SBA_RST_CTRL & (8'h01 << `SBA_CS_MODE_BIT));
      enable_reg <= 1'b0;
    end
    else
    begin
      if (cfg_wr && hit(cfg_addr, `SBA_OFF_DATA))
        data_reg <= cfg_wdata;
      // read byte lands with busy clear
      if (eng_done && !dl_wait_reg && target_reg[`SBA_TGT_RW_BIT])
        data_reg <= eng_rd_data;
      if (cfg_wr && hit(cfg_addr, `SBA_OFF_INDEX))
        index_reg <= cfg_wdata;
      // target is only written while no software cycle runs so that cycle keeps its address
      if (cfg_wr && hit(cfg_addr, `SBA_OFF_TARGET) && !sw_busy_reg)
        target_reg <= cfg_wdata;
      if (cfg_wr && hit(cfg_addr, `SBA_OFF_CTRL))
      begin
        mode_reg <= cfg_wdata[`SBA_CS_MODE_BIT];
        enable_reg <= cfg_wdata[`SBA_CS_EN_BIT];
      end
      if (pend_reg && settle_reg == `SBA_SETTLE_CYC && !global_reset_s2 && strap_s2 &&
          !eng_busy && !dl_active_reg)
        enable_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // cycle control, download sequencer and status flags
  // ----------------------------------------------------------------------
  always @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      sw_busy_reg <= 1'b0;
      dl_active_reg <= 1'b0;
      dl_wait_reg <= 1'b0;
      dl_idx_reg <= 8'h00;
      eng_start_reg <= 1'b0;
      sw_err_reg <= 1'b0;
      rom_err_reg <= 1'b0;
      dl_valid <= 1'b0;
      dl_index <= 8'h00;
      dl_data <= 8'h00;
    end
    else
    begin
      dl_valid <= 1'b0;
      eng_start_reg <= sw_go | dl_go;
      if (pend_reg && settle_reg == `SBA_SETTLE_CYC && !global_reset_s2 && strap_s2 &&
          !eng_busy && !dl_active_reg)
      begin
        dl_active_reg <= 1'b1;
        dl_idx_reg <= 8'h00;
      end
      if (dl_go)
        dl_wait_reg <= 1'b1;
      if (sw_go)
        sw_busy_reg <= 1'b1;
      else if (eng_done && !dl_wait_reg)
        sw_busy_reg <= 1'b0;
      if (eng_done && dl_wait_reg)
      begin
        dl_wait_reg <= 1'b0;
        if (eng_err)
          dl_active_reg <= 1'b0;
        else
        begin
          dl_valid <= 1'b1;
          dl_index <= dl_idx_reg;
          dl_data <= eng_rd_data;
          if (dl_idx_reg == DL_LAST)
            dl_active_reg <= 1'b0;
          else
            dl_idx_reg <= dl_idx_reg + 8'h01;
        end
      end
      // error set wins over read clear
      if (eng_done && !dl_wait_reg && eng_err)
        sw_err_reg <= 1'b1;
      else if (ctrl_read)
        sw_err_reg <= 1'b0;
      if (eng_done && dl_wait_reg && eng_err)
        rom_err_reg <= 1'b1;
      else if (ctrl_read)
        rom_err_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // read port and idle pin levels
  // ----------------------------------------------------------------------
  // unmapped offsets answer zero so the port always completes
  always @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      cfg_rdata <= 8'h00;
      cfg_rvalid <= 1'b0;
      sda_out <= 1'b0;
      scl_out <= 1'b0;
    end
    else
    begin
      cfg_rvalid <= cfg_rd;
      sda_out <= 1'b0;  // open drain: only ever pulls low
      scl_out <= 1'b0;
      if (!cfg_rd)
        cfg_rdata <= 8'h00;
      else if (hit(cfg_addr, `SBA_OFF_DATA))
        cfg_rdata <= data_reg;
      else if (hit(cfg_addr, `SBA_OFF_INDEX))
        cfg_rdata <= index_reg;
      else if (hit(cfg_addr, `SBA_OFF_TARGET))
        cfg_rdata <= target_reg;
      else if (hit(cfg_addr, `SBA_OFF_CTRL))
        cfg_rdata <= status_byte;
      else
        cfg_rdata <= 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // bus engine
  // ----------------------------------------------------------------------
  // address from target bits 7:1
  // mode bit drops the index byte
  // download reads always use the default EEPROM address with an index
  sba_twi_engine #(
    .QTR_CYC(QTR_CYC)
  ) u_engine (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .start(eng_start_reg),
    .dev_addr(dl_active_reg ? `SBA_EEPROM_ADDR :
              target_reg[`SBA_TGT_ADDR_MSB:`SBA_TGT_ADDR_LSB]),
    .rd_cmd(dl_active_reg | target_reg[`SBA_TGT_RW_BIT]),
    .addr_only(~dl_active_reg & mode_reg),
    .index_byte(dl_active_reg ? dl_idx_reg : index_reg),
    .wr_byte(data_reg),
    .sda_in(sda_s2),
    .busy(eng_busy),
    .done(eng_done),
    .err(eng_err),
    .rd_data(eng_rd_data),
    .scl_oe(scl_oe),
    .sda_oe(sda_oe)
  );

endmodule

// file: rtl/sba_map.vh
/*
  Register offsets, field positions, reset values and bus timing for the
  software serial bus access block.
  Assumes a byte-wide configuration access port and a 250 MHz ref_clk.
*/
`ifndef SBA_MAP_VH
`define SBA_MAP_VH

// ----------------------------------------------------------------------
// configuration byte offsets
// ----------------------------------------------------------------------
`define SBA_OFF_DATA 8'hb0
`define SBA_OFF_INDEX 8'hb1
`define SBA_OFF_TARGET 8'hb2
`define SBA_OFF_CTRL 8'hb3

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define SBA_TGT_RW_BIT 0
`define SBA_TGT_ADDR_MSB 7
`define SBA_TGT_ADDR_LSB 1
`define SBA_CS_MODE_BIT 7
`define SBA_CS_RSVD6_BIT 6
`define SBA_CS_BUSY_BIT 5
`define SBA_CS_DL_BIT 4
`define SBA_CS_EN_BIT 3
`define SBA_CS_RSVD2_BIT 2
`define SBA_CS_ERR_BIT 1
`define SBA_CS_ROMERR_BIT 0

// ----------------------------------------------------------------------
// reset values and the default EEPROM bus address
// ----------------------------------------------------------------------
`define SBA_RST_DATA 8'h00
`define SBA_RST_INDEX 8'h00
`define SBA_RST_TARGET 8'ha0
`define SBA_RST_CTRL 8'h00
`define SBA_EEPROM_ADDR 7'h50

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define SBA_CLK_PERIOD_NS 4
`define SBA_BIT_TIME_NS 10000
`define SBA_QTR_CYC (`SBA_BIT_TIME_NS / 4 / `SBA_CLK_PERIOD_NS)
`define SBA_SETTLE_CYC 3

`endif

// file: rtl/sba_twi_engine.v
/*
  Two-wire bus master that runs one single-byte cycle per start pulse:
  optional byte index, write or read, with a stop at the end.
  Assumes open-drain pins resolved outside and sda_in already synchronised.
*/
`include "sba_map.vh"

module sba_twi_engine #(
  parameter QTR_CYC = `SBA_QTR_CYC
)(
  input wire ref_clk,
  input wire resetn,
  input wire start,
  input wire [6:0] dev_addr,
  input wire rd_cmd,
  input wire addr_only,
  input wire [7:0] index_byte,
  input wire [7:0] wr_byte,
  input wire sda_in,
  output reg busy,
  output reg done,
  output reg err,
  output reg [7:0] rd_data,
  output reg scl_oe,
  output reg sda_oe
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_FETCH = 3'h1;
  localparam [2:0] ST_START = 3'h2;
  localparam [2:0] ST_BYTE = 3'h3;
  localparam [2:0] ST_STOP = 3'h4;
  localparam [2:0] ST_FIN = 3'h5;
  localparam [1:0] OP_START = 2'h0;
  localparam [1:0] OP_WRITE = 2'h1;
  localparam [1:0] OP_READ = 2'h2;
  localparam [1:0] OP_STOP = 2'h3;
  localparam integer QTR_LOAD_I = QTR_CYC - 1;
  localparam [15:0] QTR_LOAD = QTR_LOAD_I[15:0];

  reg [2:0] state_reg;
  reg [2:0] step_reg;
  reg [1:0] qtr_reg;
  reg [3:0] bitn_reg;
  reg [8:0] sh_reg;
  reg [7:0] rx_reg;
  reg [15:0] tcnt_reg;
  reg [6:0] addr_l;
  reg rd_l;
  reg ao_l;
  reg [7:0] idx_l;
  reg [7:0] wd_l;
  reg rd_mode_reg;
  wire tick;
  wire [3:0] op;
  reg [7:0] sel_byte;

  // op list: {opcode, byte select}; select 0 addr+write, 1 addr+read, 2 index, 3 data
  function [3:0] op_at;
    input [2:0] s;
    input r;
    input ao;
    begin
      case ({ao, r, s})
        5'b00_000, 5'b01_000, 5'b10_000, 5'b11_000: op_at = {OP_START, 2'h0};
        5'b00_001, 5'b01_001, 5'b10_001: op_at = {OP_WRITE, 2'h0};
        5'b00_010, 5'b01_010: op_at = {OP_WRITE, 2'h2};
        5'b00_011, 5'b10_010: op_at = {OP_WRITE, 2'h3};
        5'b01_011: op_at = {OP_START, 2'h0};
        5'b01_100, 5'b11_001: op_at = {OP_WRITE, 2'h1};
        5'b01_101, 5'b11_010: op_at = {OP_READ, 2'h0};
        default: op_at = {OP_STOP, 2'h0};
      endcase
    end
  endfunction

  assign op = op_at(step_reg, rd_l, ao_l);
  assign tick = (tcnt_reg == 16'h0000);

  // byte chosen by the current op
  always @*
  begin
    case (op[1:0])
      2'h0: sel_byte = {addr_l, 1'b0};
      2'h1: sel_byte = {addr_l, 1'b1};
      2'h2: sel_byte = idx_l;
      default: sel_byte = wd_l;
    endcase
  end

  // quarter-bit sequencer; every pin change lands on a quarter boundary
  always @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      state_reg <= ST_IDLE;
      step_reg <= 3'h0;
      qtr_reg <= 2'h0;
      bitn_reg <= 4'h0;
      sh_reg <= 9'h1ff;
      rx_reg <= 8'h00;
      tcnt_reg <= 16'h0000;
      addr_l <= 7'h00;
      rd_l <= 1'b0;
      ao_l <= 1'b0;
      idx_l <= 8'h00;
      wd_l <= 8'h00;
      rd_mode_reg <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      err <= 1'b0;
      rd_data <= 8'h00;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      tcnt_reg <= tick ? QTR_LOAD : tcnt_reg - 16'h0001;
      case (state_reg)
        ST_IDLE:
        begin
          if (start)
          begin
            addr_l <= dev_addr;
            rd_l <= rd_cmd;
            ao_l <= addr_only;
            idx_l <= index_byte;
            wd_l <= wr_byte;
            step_reg <= 3'h0;
            err <= 1'b0;
            busy <= 1'b1;
            state_reg <= ST_FETCH;
          end
        end
        ST_FETCH:
        begin
          // restart the quarter timer so each phase is full length
          tcnt_reg <= QTR_LOAD;
          qtr_reg <= 2'h0;
          bitn_reg <= 4'h0;
          rd_mode_reg <= (op[3:2] == OP_READ);
          sh_reg <= (op[3:2] == OP_WRITE) ? {sel_byte, 1'b1} : 9'h1ff;
          case (op[3:2])
            OP_START: state_reg <= ST_START;
            OP_STOP: state_reg <= ST_STOP;
            default: state_reg <= ST_BYTE;
          endcase
        end
        ST_START:
        begin
          if (tick)
          begin
            qtr_reg <= qtr_reg + 2'h1;
            case (qtr_reg)
              2'h0: sda_oe <= 1'b0;
              2'h1: scl_oe <= 1'b0;
              2'h2: sda_oe <= 1'b1;
              default:
              begin
                scl_oe <= 1'b1;
                step_reg <= step_reg + 3'h1;
                state_reg <= ST_FETCH;
              end
            endcase
          end
        end
        ST_BYTE:
        begin
          if (tick)
          begin
            qtr_reg <= qtr_reg + 2'h1;
            case (qtr_reg)
              2'h0: sda_oe <= ~sh_reg[8];
              2'h1: scl_oe <= 1'b0;
              2'h2:
              begin
                if (bitn_reg != 4'h8)
                  rx_reg <= {rx_reg[6:0], sda_in};
                else if (!rd_mode_reg && sda_in)
                  err <= 1'b1;  // no acknowledge from the target
              end
              default:
              begin
                scl_oe <= 1'b1;
                sh_reg <= {sh_reg[7:0], 1'b1};
                bitn_reg <= bitn_reg + 4'h1;
                if (bitn_reg == 4'h8)
                begin
                  step_reg <= step_reg + 3'h1;
                  // a failed acknowledge skips straight to the stop
                  state_reg <= err ? ST_STOP : ST_FETCH;
                end
              end
            endcase
          end
        end
        ST_STOP:
        begin
          if (tick)
          begin
            qtr_reg <= qtr_reg + 2'h1;
            case (qtr_reg)
              2'h0: sda_oe <= 1'b1;
              2'h1: scl_oe <= 1'b0;
              2'h2: sda_oe <= 1'b0;
              default: state_reg <= ST_FIN;
            endcase
          end
        end
        ST_FIN:
        begin
          rd_data <= rx_reg;
          busy <= 1'b0;
          done <= 1'b1;
          state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

endmodule

// file: tb/sba_ctrl_monitor.sv
/*
  Port checker for sba_ctrl, bound into every instance.
  Assumes one-cycle config strobes and resetn as the only reset.
*/
module sba_ctrl_monitor #(
  parameter DL_BYTES = 8
)(
  input wire ref_clk,
  input wire resetn,
  input wire cfg_wr,
  input wire cfg_rd,
  input wire [7:0] cfg_addr,
  input wire [7:0] cfg_rdata,
  input wire cfg_rvalid,
  input wire sda_out,
  input wire scl_out,
  input wire dl_valid,
  input wire [7:0] dl_index
);
  timeunit 1ns;
  timeprecision 1ps;
  reg tgt_wr_reg;
  reg [1:0] age_reg;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // ----------------------------------------
  // helper state
  // ----------------------------------------
  // target written since reset, and age since release (saturates)
  always @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      tgt_wr_reg <= 1'b0;
      age_reg <= 2'h0;
    end
    else
    begin
      if (cfg_wr && cfg_addr == 8'hb2)
        tgt_wr_reg <= 1'b1;
      if (age_reg != 2'h3)
        age_reg <= age_reg + 2'h1;
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  // read port timing, then register contents and pin behaviour
  AST_RVALID_AFTER_RD: assert property (cfg_rd |=> cfg_rvalid)
    else $error("read strobe without valid");
  AST_NO_STRAY_RVALID: assert property (!cfg_rd |=> !cfg_rvalid)
    else $error("valid without read strobe");
  AST_RDATA_IDLE_ZERO: assert property (!cfg_rvalid |-> cfg_rdata == 8'h00)
    else $error("read data not zero while idle");
  AST_UNMAPPED_ZERO: assert property (cfg_rd && (cfg_addr < 8'hb0 || cfg_addr > 8'hb3)
    |=> cfg_rdata == 8'h00) else $error("unmapped read not zero");
  AST_RSVD_ZERO: assert property (
    cfg_rd && cfg_addr == 8'hb3 |=> !cfg_rdata[6] && !cfg_rdata[2])
    else $error("reserved status bits set");
  AST_TARGET_RESET: assert property (
    cfg_rd && cfg_addr == 8'hb2 && !tgt_wr_reg |=> cfg_rdata == 8'ha0)
    else $error("target address not at reset value");
  AST_CTRL_RESET: assert property (
    cfg_rd && cfg_addr == 8'hb3 && age_reg < 2'h2 |=> cfg_rdata == 8'h00)
    else $error("control status not clear after reset");
  AST_OPEN_DRAIN: assert property (!sda_out && !scl_out)
    else $error("bus pin driven high");
  AST_DL_RANGE: assert property (dl_valid |-> dl_index < DL_BYTES)
    else $error("download index out of range");
  AST_DL_PULSE: assert property (dl_valid |=> !dl_valid [*8])
    else $error("download strobe too long");
endmodule

bind sba_ctrl sba_ctrl_monitor #(.DL_BYTES(DL_BYTES)) u_mon (.ref_clk, .resetn,
  .cfg_wr, .cfg_rd, .cfg_addr, .cfg_rdata, .cfg_rvalid, .sda_out, .scl_out,
  .dl_valid, .dl_index);

// file: tb/sba_eeprom_model.sv
/*
  Behavioural two-wire EEPROM target with byte index pointer.
  Assumes pulled-up wires resolved by the bench; sda_pull high pulls low.
*/
module sba_eeprom_model #(
  parameter logic [6:0] DEV_ADDR = 7'h50
)(
  input wire scl,
  input wire sda,
  output logic sda_pull
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:255];
  logic [7:0] sh, ptr;
  logic [1:0] phase;
  logic active;
  int bitn;
  // known contents, so every read can be predicted
  initial
  begin
    sda_pull = 1'b0;
    active = 1'b0;
    ptr = 8'h00;
    for (int i = 0; i < 256; i++)
      mem[i] = 8'h30 + i[7:0];
  end
  // start and stop seen as data edges while the clock is high
  always @(negedge sda)
    if (scl === 1'b1)
    begin
      active = 1'b1;
      bitn = -1;
      phase = 2'h0;
    end
  always @(posedge sda)
    if (scl === 1'b1)
    begin
      active = 1'b0;
      sda_pull = 1'b0;
    end
  // shift in on the rising clock
  always @(posedge scl)
    if (active && bitn >= 0 && bitn < 8)
      sh = {sh[6:0], sda};
    // a not-acknowledge from the master ends the read, so the line is freed for the stop
    else if (active && phase == 2'h3 && bitn == 8 && sda === 1'b1)
      active = 1'b0;
  // drive on the falling clock: acknowledge or read bits, msb first
  always @(negedge scl)
    if (active)
    begin
      bitn = (bitn == 8) ? 0 : bitn + 1;
      sda_pull = 1'b0;
      if (phase == 2'h3)
      begin
        if (bitn < 8)
          sda_pull = ~mem[ptr][7 - bitn];
        else
          ptr = ptr + 8'h01;
      end
      else if (bitn == 8)
      begin
        if (phase != 2'h0)
        begin
          if (phase == 2'h2)
            mem[ptr] = sh;
          ptr = (phase == 2'h2) ? ptr + 8'h01 : sh;
          phase = 2'h2;
          sda_pull = 1'b1;
        end
        // a foreign address is left unanswered
        else if (sh[7:1] == DEV_ADDR)
        begin
          sda_pull = 1'b1;
          phase = sh[0] ? 2'h3 : 2'h1;
        end
        else
          active = 1'b0;
      end
    end
endmodule

// file: tb/test_serial_bus_sw_access_ctrl.sv
/*
  Self-checking bench for sba_ctrl with a two-wire EEPROM model.
  Assumes the checker is bound from its own file.
*/
module test_serial_bus_sw_access_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DLB = 8;
  logic ref_clk = 1'b0, resetn = 1'b0, cfg_wr = 1'b0, cfg_rd = 1'b0;
  logic [7:0] cfg_addr = 8'h00, cfg_wdata = 8'h00;
  logic eeprom_strap = 1'b0, global_reset = 1'b0;
  wire [7:0] cfg_rdata, dl_index, dl_data;
  wire cfg_rvalid, sda_out, sda_oe, scl_out, scl_oe, dl_valid, sda_pull;
  wire scl = ~scl_oe;
  wire sda = ~(sda_oe | sda_pull);
  int n_errors = 0, n_compared = 0;
  logic [15:0] dlq [$];
  sba_ctrl #(.QTR_CYC(4), .DL_BYTES(DLB)) dut (.ref_clk(ref_clk), .resetn(resetn),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .eeprom_strap(eeprom_strap),
    .global_reset(global_reset), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .scl_out(scl_out), .scl_oe(scl_oe), .dl_valid(dl_valid), .dl_index(dl_index),
    .dl_data(dl_data));
  sba_eeprom_model u_ee (.scl(scl), .sda(sda), .sda_pull(sda_pull));
  // 250 MHz clock
  initial
    forever #2 ref_clk = ~ref_clk;
  // record every downloaded byte with its index
  always @(posedge ref_clk)
    if (dl_valid === 1'b1)
      dlq.push_back({dl_index, dl_data});
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic test_done();
    if (n_errors == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rst(input logic strap);
    @(posedge ref_clk);
    resetn <= 1'b0;
    eeprom_strap <= strap;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    cfg_wr <= 1'b1;
    cfg_addr <= a;
    cfg_wdata <= d;
    @(posedge ref_clk);
    cfg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    cfg_rd <= 1'b1;
    cfg_addr <= a;
    @(posedge ref_clk);
    cfg_rd <= 1'b0;
    #1;
    d = (cfg_rvalid === 1'b1) ? cfg_rdata : 8'hxx;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(d, e);
  endtask
  // status polling; a read clears the error bits, so they are collected
  task automatic poll(input logic [7:0] m, v, output logic [7:0] last, acc);
    acc = 8'h00;
    for (int i = 0; i < 5000; i++)
    begin
      rd(8'hb3, last);
      acc = acc | last;
      if ((last & m) === v)
        return;
    end
    chk(last & m, v);
    test_done();
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic s_reset();
    rc(8'hb3, 8'h00);
    rc(8'hb2, 8'ha0);
    rc(8'hb0, 8'h00);
    rc(8'hb1, 8'h00);
    rc(8'h40, 8'h00);
    repeat (30) @(posedge ref_clk);
    rc(8'hb3, 8'h00);
  endtask
  task automatic s_disabled();
    logic seen;
    seen = 1'b0;
    wr(8'hb2, 8'ha0);
    repeat (40)
    begin
      @(posedge ref_clk);
      seen = seen | scl_oe | sda_oe;
    end
    chk(seen, 1'b0);
    rc(8'hb3, 8'h00);
    wr(8'hb3, 8'hff);
    rc(8'hb3, 8'h88);
    wr(8'hb3, 8'h08);
    rc(8'hb3, 8'h08);
  endtask
  task automatic s_write();
    logic [7:0] st, acc;
    wr(8'hb0, 8'h5a);
    wr(8'hb1, 8'h10);
    wr(8'hb2, 8'ha0);
    wr(8'hb2, 8'hc4);
    rc(8'hb3, 8'h28);
    poll(8'h30, 8'h00, st, acc);
    chk(st, 8'h08);
    chk(u_ee.mem[16], 8'h5a);
    rc(8'hb2, 8'ha0);
    wr(8'hb3, 8'h88);
    wr(8'hb0, 8'ha5);
    wr(8'hb2, 8'ha0);
    poll(8'h30, 8'h00, st, acc);
    chk(st, 8'h88);
    chk(u_ee.ptr, 8'ha5);
    wr(8'hb3, 8'h08);
  endtask
  task automatic s_read();
    logic [7:0] st, acc;
    wr(8'hb1, 8'h10);
    wr(8'hb2, 8'ha1);
    poll(8'h30, 8'h00, st, acc);
    rc(8'hb0, 8'h5a);
    wr(8'hb3, 8'h88);
    wr(8'hb2, 8'ha1);
    poll(8'h30, 8'h00, st, acc);
    chk(st, 8'h88);
    rc(8'hb0, 8'h41);
  endtask
  task automatic s_error();
    logic [7:0] st, acc;
    wr(8'hb3, 8'h08);
    wr(8'hb2, 8'hb0);
    poll(8'h30, 8'h00, st, acc);
    chk(acc & 8'h02, 8'h02);
    rc(8'hb3, 8'h08);
  endtask
  task automatic s_download();
    logic [7:0] st, acc;
    rst(1'b1);
    rc(8'hb3, 8'h00);
    rc(8'hb0, 8'h00);
    poll(8'h18, 8'h18, st, acc);
    poll(8'h30, 8'h00, st, acc);
    chk(st, 8'h08);
    chk(16'(dlq.size()), 16'(DLB));
    for (int i = 0; i < DLB; i++)
      chk(dlq[i], {i[7:0], 8'h30 + i[7:0]});
    @(posedge ref_clk);
    eeprom_strap <= 1'b0;
    repeat (20) @(posedge ref_clk);
    rc(8'hb3, 8'h08);
    wr(8'hb3, 8'h00);
    @(posedge ref_clk);
    eeprom_strap <= 1'b1;
    repeat (20) @(posedge ref_clk);
    rc(8'hb3, 8'h00);
    @(posedge ref_clk);
    global_reset <= 1'b1;
    repeat (4) @(posedge ref_clk);
    global_reset <= 1'b0;
    poll(8'h18, 8'h18, st, acc);
    poll(8'h30, 8'h00, st, acc);
    chk(16'(dlq.size()), 16'(2 * DLB));
  endtask
  // main sequence
  initial
  begin
    rst(1'b0);
    s_reset();
    s_disabled();
    s_write();
    s_read();
    s_error();
    s_download();
    test_done();
  end
endmodule
